// ---- spm_serial_peripheral_master.sv ----
// Purpose: apb-controlled master-only serial port, four selects
// Assumes: all inputs synchronous to pclk; pready high one cycle
// Notes: no transmit buffer; refill data during the running character
`timescale 1ns/1ps
`default_nettype none
module spm_serial_peripheral_master (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in,
  output logic serial_clk,
  output logic serial_out,
  output logic [3:0] slave_select_n,
  output logic irq
);
  logic [15:0] div;
  logic [15:0] ccr;
  logic [15:0] cfg_lo;
  logic [15:0] cfg_hi;
  logic [15:0] cmd_lo;
  logic [15:0] cmd_hi;
  logic [15:0] dat_lo;
  logic [15:0] dat_hi;
  logic [31:0] rxd;
  logic [1:0] istat;
  logic [1:0] imask;
  spm_pkg::spm_state_t state;
  logic [15:0] hcnt;
  logic ph;
  logic [2:0] lcnt;
  logic [4:0] bidx;
  logic [4:0] len_m1;
  logic [11:0] ccnt;
  logic [31:0] shreg;
  logic txd_bit;
  logic [1:0] sel;
  spm_pkg::spm_slave_t cfg;

  // apb decode
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite & pready;
  wire [13:0] widx = paddr[15:2];
  wire aligned = paddr[1:0] == 2'b00;
  wire h_div = aligned & (widx == spm_pkg::IDX_DIV[13:0]);
  wire h_ccr = aligned & (widx == spm_pkg::IDX_CCR[13:0]);
  wire h_cfgl = aligned & (widx == spm_pkg::IDX_CFG_LO[13:0]);
  wire h_cfgh = aligned & (widx == spm_pkg::IDX_CFG_HI[13:0]);
  wire h_cmdl = aligned & (widx == spm_pkg::IDX_CMD_LO[13:0]);
  wire h_cmdh = aligned & (widx == spm_pkg::IDX_CMD_HI[13:0]);
  wire h_stl = aligned & (widx == spm_pkg::IDX_STAT_LO[13:0]);
  wire h_sth = aligned & (widx == spm_pkg::IDX_STAT_HI[13:0]);
  wire h_datl = aligned & (widx == spm_pkg::IDX_DAT_LO[13:0]);
  wire h_dath = aligned & (widx == spm_pkg::IDX_DAT_HI[13:0]);
  wire h_ist = aligned & (widx == spm_pkg::IDX_ISTAT[13:0]);
  wire h_imk = aligned & (widx == spm_pkg::IDX_IMASK[13:0]);
  wire mapped = h_div | h_ccr | h_cfgl | h_cfgh | h_cmdl | h_cmdh | h_stl | h_sth
    | h_datl | h_dath | h_ist | h_imk;

  wire busy = state != spm_pkg::ST_IDLE;
  wire [15:0] stat_lo = {13'h0000, istat[spm_pkg::IRQ_FRAME],
    istat[spm_pkg::IRQ_CHAR], busy};
  wire [15:0] stat_hi = {4'h0, ccnt};
  wire [15:0] rd_mux = h_div ? div : h_ccr ? ccr : h_cfgl ? cfg_lo : h_cfgh ? cfg_hi
    : h_cmdl ? cmd_lo : h_cmdh ? cmd_hi : h_stl ? stat_lo : h_sth ? stat_hi
    : h_datl ? rxd[15:0] : h_dath ? rxd[31:16] : h_ist ? {14'h0000, istat}
    : h_imk ? {14'h0000, imask} : 16'h0000;

  // bit clock engine
  wire [31:0] cfg_all = {cfg_hi, cfg_lo};
  wire [4:0] cfg_pos = {pwdata[1:0], spm_pkg::CFG_STRIDE_LSB};
  wire spm_pkg::spm_slave_t next_cfg = spm_pkg::spm_slave_t'(cfg_all[cfg_pos +: 5]);
  wire [4:0] next_len = pwdata[spm_pkg::CMDH_LEN +: 5];
  wire [31:0] tx_word = {dat_hi, dat_lo};
  wire start = wr & h_cmdh & ccr[spm_pkg::CCR_EN] & ~busy;
  wire tick = busy & (hcnt == div); // see RL5
  wire in_shift = state == spm_pkg::ST_SHIFT;
  wire lead_edge = in_shift & tick & ~ph;
  wire trail_edge = in_shift & tick & ph;
  wire samp = cfg.ckph ? trail_edge : lead_edge; // see RL9
  wire shft = cfg.ckph ? lead_edge : trail_edge; // see RL9
  wire rx_bit = ccr[spm_pkg::CCR_LOOP] ? txd_bit : serial_in; // see RL10
  wire [31:0] shreg_in = {shreg[30:0], rx_bit}; // see RL2
  wire [31:0] next_sh = samp ? shreg_in : shreg;
  wire [31:0] len_mask = 32'hFFFF_FFFF >> (5'd31 - len_m1);
  wire last_bit = bidx == 5'd0;
  wire char_end = trail_edge & last_bit; // see RL1
  wire frame_end = char_end & (ccnt == 12'h000);
  wire lead_done = (state == spm_pkg::ST_LEAD) & tick & (lcnt == {cfg.dly, 1'b0});
  wire [1:0] set_ist = {frame_end, char_end & cmd_lo[spm_pkg::CMDL_CIE]}; // see RL7
  wire [1:0] clr_ist = (wr & h_ist) ? pwdata[1:0] : 2'b00;
  wire [1:0] next_istat = set_ist | (istat & ~clr_ist);

  // apb slave registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= spm_pkg::DIV_RST;
      ccr <= spm_pkg::REG_RST;
      cfg_lo <= spm_pkg::REG_RST;
      cfg_hi <= spm_pkg::REG_RST;
      cmd_lo <= spm_pkg::REG_RST;
      cmd_hi <= spm_pkg::REG_RST;
      dat_lo <= spm_pkg::REG_RST;
      dat_hi <= spm_pkg::REG_RST;
      imask <= 2'b00;
    end else if (wr) begin
      if (h_div) div <= pwdata[15:0]; // see RL5
      if (h_ccr) ccr <= pwdata[15:0];
      if (h_cfgl) cfg_lo <= pwdata[15:0];
      if (h_cfgh) cfg_hi <= pwdata[15:0];
      if (h_cmdl) cmd_lo <= pwdata[15:0];
      if (h_cmdh) cmd_hi <= pwdata[15:0];
      if (h_datl) dat_lo <= pwdata[15:0];
      if (h_dath) dat_hi <= pwdata[15:0];
      if (h_imk) imask <= pwdata[1:0];
    end
  end

  // sticky events, set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat <= 2'b00;
      irq <= 1'b0;
    end else begin
      istat <= next_istat;
      irq <= |(istat & imask);
    end
  end

  // frame sequencer; commands while busy are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= spm_pkg::ST_IDLE;
      hcnt <= 16'h0000;
      ph <= 1'b0;
      lcnt <= 3'b000;
      bidx <= 5'd0;
      len_m1 <= 5'd0;
      ccnt <= 12'h000;
      shreg <= 32'h0000_0000;
      txd_bit <= 1'b0;
      sel <= 2'b00;
      cfg <= '0;
      rxd <= 32'h0000_0000;
    end else begin
      hcnt <= (tick | ~busy) ? 16'h0000 : hcnt + 16'h0001;
      shreg <= next_sh;
      unique case (state)
        spm_pkg::ST_IDLE: begin
          if (start) begin // see RL3
            state <= spm_pkg::ST_LEAD;
            sel <= pwdata[1:0];
            cfg <= next_cfg;
            len_m1 <= next_len;
            bidx <= next_len;
            ccnt <= cmd_lo[11:0]; // see RL6
            shreg <= tx_word;
            txd_bit <= tx_word[next_len];
            lcnt <= 3'b000;
            ph <= 1'b0;
          end
        end
        spm_pkg::ST_LEAD: begin
          if (lead_done) begin // see RL8
            state <= spm_pkg::ST_SHIFT;
          end else if (tick) begin
            lcnt <= lcnt + 3'b001;
          end
        end
        spm_pkg::ST_SHIFT: begin
          if (tick) ph <= ~ph;
          if (shft) txd_bit <= next_sh[len_m1]; // see RL2
          if (trail_edge & ~last_bit) bidx <= bidx - 5'd1;
          if (char_end) begin
            rxd <= next_sh & len_mask; // see RL1
            bidx <= len_m1;
            shreg <= tx_word;
            txd_bit <= tx_word[len_m1];
            if (frame_end) begin
              state <= spm_pkg::ST_TRAIL;
            end else begin
              ccnt <= ccnt - 12'h001; // see RL6
            end
          end
        end
        spm_pkg::ST_TRAIL: begin
          if (tick) state <= spm_pkg::ST_IDLE; // see RL11
        end
      endcase
    end
  end

  // pins; clock and data share one register stage so they stay aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_clk <= 1'b0;
      serial_out <= 1'b0;
    end else begin
      serial_clk <= ph ^ cfg.ckp; // see RL9
      serial_out <= txd_bit;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_sel
      wire spm_pkg::spm_slave_t kcfg = spm_pkg::spm_slave_t'(cfg_all[8 * k +: 5]);
      wire active = busy & (sel == 2'(k));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          slave_select_n[k] <= 1'b1;
        end else begin
          slave_select_n[k] <= kcfg.csp ? active : ~active; // see RL4
        end
      end
    end
  endgenerate

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_samp_plain;
    samp && !char_end;
  endsequence

  a_char_bits: assert property (trail_edge && !last_bit |=> bidx == $past(bidx) - 5'd1) // see RL1
    else $error("bit counter did not step");
  a_duplex_capture: assert property (s_samp_plain |=> shreg[0] == $past(rx_bit)) // see RL2
    else $error("receive bit not captured");
  a_master_only: assert property (!busy && !start |=> !busy) // see RL3
    else $error("frame began without a command");
  a_select_active: assert property (in_shift |=> slave_select_n[sel] == cfg.csp) // see RL4
    else $error("selected slave not asserted");
  a_divider_tick: assert property (tick && div != 16'h0000 |=> !tick) // see RL5
    else $error("half period shorter than divider");
  a_frame_stop: assert property (frame_end |=> state == spm_pkg::ST_TRAIL) // see RL6
    else $error("frame did not stop at last character");
  a_char_irq_gate: assert property ($rose(istat[0]) |-> $past(cmd_lo[14])) // see RL7
    else $error("character interrupt while disabled");
  a_lead_delay: assert property (lead_done |=> in_shift ##0 lcnt <= 3'd6) // see RL8
    else $error("lead delay wrong");
  a_edge_choice: assert property (samp |-> ph == cfg.ckph) // see RL9
    else $error("sample on wrong edge");
  a_loop_path: assert property (ccr[1] && samp && !char_end |=> shreg[0] == $past(txd_bit)) // see RL10
    else $error("loopback bit missing");
  // a start in this cycle loads a new idle level, so it is left out
  a_idle_clock: assert property (!busy && !start && $past(!busy) |=> serial_clk == cfg.ckp) // see RL11
    else $error("clock not at idle level");

  // multi-step behaviours
  sequence s_begin;
    start ##1 busy;
  endsequence

  sequence s_tail;
    frame_end ##1 state == spm_pkg::ST_TRAIL;
  endsequence

  sequence s_char_done;
    char_end && cmd_lo[spm_pkg::CMDL_CIE];
  endsequence

  sequence s_lead_end;
    lead_done ##1 in_shift;
  endsequence

  // register bus
  a_ready_pulse: assert property ( // see RL5
    pready |=> !pready)
    else $error("ready stood more than one cycle");
  a_err_ready: assert property ( // see RL5
    pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property ( // see RL5
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  a_rdata_upper: assert property ( // see RL5
    prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_unmapped_zero: assert property ( // see RL5
    pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_stat_busy: assert property ( // see RL11
    pready && $past(setup && h_stl) |-> prdata[0] == $past(busy))
    else $error("busy bit misreported");
  a_div_write: assert property ( // see RL5
    wr && h_div |=> div == $past(pwdata[15:0]))
    else $error("divider write lost");

  // sticky events and interrupt
  a_irq_follow: assert property ( // see RL7
    |(istat & imask) |=> irq)
    else $error("interrupt missing");
  a_irq_quiet: assert property ( // see RL7
    !(|(istat & imask)) |=> !irq)
    else $error("interrupt without cause");
  a_flag_sticky: assert property ( // see RL6
    istat[1] && !(wr && h_ist && pwdata[1]) |=> istat[1])
    else $error("frame flag lost");
  a_flag_clear: assert property ( // see RL7
    wr && h_ist && pwdata[0] && !set_ist[0] |=> !istat[0])
    else $error("flag not cleared");
  a_frame_flag: assert property ( // see RL6
    frame_end |=> istat[1])
    else $error("frame flag not set");
  a_char_flag: assert property ( // see RL7
    s_char_done |=> istat[0])
    else $error("character flag not set");

  // frame sequencer
  a_enable_gate: assert property ( // see RL3
    !ccr[0] && !busy |=> !busy)
    else $error("frame began while disabled");
  a_start_lead: assert property ( // see RL8
    start |=> state == spm_pkg::ST_LEAD)
    else $error("start did not enter lead");
  a_cmd_dropped: assert property ( // see RL6
    busy && wr && h_cmdh |=> $stable(sel))
    else $error("command taken while busy");
  a_sel_stable: assert property ( // see RL4
    busy && $past(busy) |-> $stable(sel))
    else $error("slave changed in frame");
  a_cfg_stable: assert property ( // see RL9
    busy && $past(busy) |-> $stable(cfg))
    else $error("mode changed in frame");
  a_lead_select: assert property ( // see RL4
    s_begin |=> slave_select_n[sel] == cfg.csp)
    else $error("select late after start");
  a_lcnt_bound: assert property ( // see RL8
    state == spm_pkg::ST_LEAD |-> lcnt <= 3'd6)
    else $error("lead counter overrun");
  a_lead_phase: assert property ( // see RL8
    s_lead_end |-> !ph)
    else $error("shift began mid period");
  a_hcnt_bound: assert property ( // see RL5
    busy |-> hcnt <= div)
    else $error("divider counter overrun");
  a_phase_rest: assert property ( // see RL11
    !in_shift |-> !ph)
    else $error("phase left high outside shift");
  a_data_hold: assert property ( // see RL2
    in_shift && !shft && !char_end |=> $stable(txd_bit))
    else $error("transmit bit moved off edge");
  a_rx_masked: assert property ( // see RL1
    char_end |=> (rxd & ~len_mask) == 32'h0000_0000)
    else $error("received bits above length");
  a_count_step: assert property ( // see RL6
    char_end && !frame_end |=> ccnt == $past(ccnt) - 12'h001)
    else $error("character count did not step");
  a_bits_reload: assert property ( // see RL1
    char_end |=> bidx == len_m1)
    else $error("bit counter not reloaded");
  a_trail_select: assert property ( // see RL11
    s_tail |=> slave_select_n[sel] == cfg.csp)
    else $error("select dropped before trail");
  a_trail_end: assert property ( // see RL11
    state == spm_pkg::ST_TRAIL && tick |=> !busy)
    else $error("trail did not end");

  // pins
  a_pin_data: assert property ( // see RL2
    1'b1 |=> serial_out == $past(txd_bit))
    else $error("data pin not aligned");
  a_pin_clock: assert property ( // see RL9
    1'b1 |=> serial_clk == $past(ph ^ cfg.ckp))
    else $error("clock pin wrong polarity");
  a_idle_selects: assert property ( // see RL4
    !busy && $past(!busy)
      |-> slave_select_n == $past(~{cfg_all[26], cfg_all[18], cfg_all[10], cfg_all[2]}))
    else $error("idle select level wrong");
endmodule : spm_serial_peripheral_master
`default_nettype wire

// ---- spm_pkg.sv ----
// Purpose: constants and types of the serial peripheral master
// Assumes: apb byte address is four times the register index
// Notes: layouts of fields are local to this block
// Operation
// RL1 - characters of 1 to 32 bits shift at a software-set bit rate
// RL2 - each bit period shifts one bit out and captures one in
// RL3 - always link master; makes serial clock and selects itself
// RL4 - four independent slave-select outputs share clock and data lines
// RL5 - bit clock comes from system clock through programmable divider
// RL6 - a frame holds 1 to 4096 characters back to back, one selection
// RL7 - optional interrupt on each finished character; none when disabled
// RL8 - 0 to 3 serial clock cycles between select and first bit; here the lead lasts 2 x dly + 1 half periods, 0.5 to 3.5 cycles
// RL9 - software picks active clock edge, clock and select polarity
// RL10 - loopback routes transmit data into receive path internally
// RL11 - after the frame, select drops and clock returns to idle level
package spm_pkg;
  // register indices; byte address is index times four
  localparam logic [15:0] IDX_DIV = 16'h3000;
  localparam logic [15:0] IDX_CCR = 16'h3001;
  localparam logic [15:0] IDX_CFG_LO = 16'h3002;
  localparam logic [15:0] IDX_CFG_HI = 16'h3003;
  localparam logic [15:0] IDX_CMD_LO = 16'h3004;
  localparam logic [15:0] IDX_CMD_HI = 16'h3005;
  localparam logic [15:0] IDX_STAT_LO = 16'h3006;
  localparam logic [15:0] IDX_STAT_HI = 16'h3007;
  localparam logic [15:0] IDX_DAT_LO = 16'h3008;
  localparam logic [15:0] IDX_DAT_HI = 16'h3009;
  localparam logic [15:0] IDX_ISTAT = 16'h300A;
  localparam logic [15:0] IDX_IMASK = 16'h300B;
  // reset values
  localparam logic [15:0] DIV_RST = 16'h0003;
  localparam logic [15:0] REG_RST = 16'h0000;
  // field positions
  localparam int CCR_EN = 0;
  localparam int CCR_LOOP = 1;
  localparam int CMDL_CIE = 14;
  localparam int CMDH_LEN = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_CHAR = 1;
  localparam int ST_FRAME = 2;
  localparam int IRQ_CHAR = 0;
  localparam int IRQ_FRAME = 1;
  localparam logic [2:0] CFG_STRIDE_LSB = 3'b000;

  typedef struct packed {
    logic [1:0] dly;
    logic csp;
    logic ckph;
    logic ckp;
  } spm_slave_t;

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL} spm_state_t;
endpackage : spm_pkg

// ---- spm_slave_model.sv ----
// Purpose: behavioural serial slave on select 0, clock mode 0
// Assumes: select active low, data launched on falling clock
// Notes: released line shows inverse of last bit, never a held value
`timescale 1ns/1ps
`default_nettype none
module spm_slave_model (
  input wire logic serial_clk,
  input wire logic serial_out,
  input wire logic sel_n,
  input wire logic [31:0] resp,
  output logic serial_in,
  output logic [31:0] got
);
  logic [31:0] sh = 32'h0000_0000;
  logic last = 1'b0;
  initial got = 32'h0000_0000;
  // reply preloaded at selection, msb first
  always @(negedge sel_n) begin
    sh <= resp;
    got <= 32'h0000_0000;
  end
  always @(posedge serial_clk) if (!sel_n) got <= {got[30:0], serial_out};
  always @(negedge serial_clk) if (!sel_n) sh <= {sh[30:0], 1'b0};
  always @(posedge sel_n) last <= sh[31];
  // no pull on the line: a stale value must not pass for data
  assign serial_in = sel_n ? ~last : sh[31];
endmodule : spm_slave_model
`default_nettype wire

// ---- tb_serial_peripheral_master.sv ----
// Purpose: self-checking bench of the serial peripheral master
// Assumes: slave model on select 0; loopback used for other modes
// Notes: apb master waits for pready, bounded by its own count
`timescale 1ns/1ps
`default_nettype none
module tb_serial_peripheral_master;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic serial_in, serial_clk, serial_out, irq;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, resp, got;
  logic [3:0] slave_select_n;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_edges = 0;
  spm_serial_peripheral_master uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_in(serial_in), .serial_clk(serial_clk),
    .serial_out(serial_out), .slave_select_n(slave_select_n), .irq(irq));
  spm_slave_model slv (.serial_clk(serial_clk), .serial_out(serial_out),
    .sel_n(slave_select_n[0]), .resp(resp), .serial_in(serial_in), .got(got));
  always @(posedge serial_clk) n_edges++;
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] i, input logic [15:0] wd,
                     output logic [15:0] rd, output logic er);
    int n;
    @(posedge pclk);
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i[13:0], 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata[15:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(0, 1, "no pready");
  endtask : apb
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    logic [15:0] r;
    logic e;
    apb(1'b1, i, d, r, e);
  endtask : wr
  task automatic rdchk(input logic [15:0] i, input logic [15:0] x, input string m);
    logic [15:0] r;
    logic e;
    apb(1'b0, i, 16'h0000, r, e);
    chk({15'h0000, e, r}, {16'h0000, x}, m);
  endtask : rdchk
  task automatic wait_idle();
    logic [15:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, spm_pkg::IDX_STAT_LO, 16'h0000, r, e);
      n++;
    end while (r[spm_pkg::ST_BUSY] !== 1'b0 && n < 500);
    if (n >= 500) chk(0, 1, "busy stuck");
  endtask : wait_idle
  task automatic t_reset();
    logic [15:0] r;
    logic e;
    chk(slave_select_n, 4'hF, "idle selects");
    rdchk(spm_pkg::IDX_DIV, 16'h0003, "divider reset");
    rdchk(spm_pkg::IDX_CCR, 16'h0000, "control reset");
    apb(1'b0, 16'h3010, 16'h0000, r, e);
    chk({15'h0000, e, r}, 32'h0001_0000, "unmapped");
    wr(spm_pkg::IDX_STAT_LO, 16'hFFFF);
    rdchk(spm_pkg::IDX_STAT_LO, 16'h0000, "status read only");
    $display("done reset");
  endtask : t_reset
  task automatic t_mode0();
    wr(spm_pkg::IDX_CCR, 16'h0001);
    wr(spm_pkg::IDX_DAT_LO, 16'h00A5);
    resp = 32'h3C00_0000;
    n_edges = 0;
    wr(spm_pkg::IDX_CMD_LO, 16'h0000);
    wr(spm_pkg::IDX_CMD_HI, 16'h001C);
    wait_idle();
    chk(n_edges, 8, "bit count");
    chk(got[7:0], 8'hA5, "msb first out");
    rdchk(spm_pkg::IDX_DAT_LO, 16'h003C, "received");
    chk(slave_select_n, 4'hF, "select released");
    chk(serial_clk, 1'b0, "clock idle");
    rdchk(spm_pkg::IDX_ISTAT, 16'h0002, "no char irq");
    wr(spm_pkg::IDX_ISTAT, 16'h0003);
    $display("done mode0");
  endtask : t_mode0
  task automatic t_lead();
    int c;
    wr(spm_pkg::IDX_DIV, 16'h0001);
    wr(spm_pkg::IDX_CFG_LO, 16'h0018);
    wr(spm_pkg::IDX_CMD_HI, 16'h001C);
    c = 0;
    while (slave_select_n[0] !== 1'b0 && c < 50) begin
      @(posedge pclk);
      c++;
    end
    c = 0;
    while (serial_clk !== 1'b1 && c < 200) begin
      @(posedge pclk);
      c++;
    end
    chk(c, 16, "lead of 7 halves of 2 then first half");
    wait_idle();
    $display("done lead");
  endtask : t_lead
  task automatic t_irq();
    wr(spm_pkg::IDX_IMASK, 16'h0001);
    wr(spm_pkg::IDX_CMD_LO, 16'h4000);
    wr(spm_pkg::IDX_CMD_HI, 16'h001C);
    wait_idle();
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1, "char irq");
    rdchk(spm_pkg::IDX_ISTAT, 16'h0003, "flags set");
    wr(spm_pkg::IDX_IMASK, 16'h0000);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "masked");
    wr(spm_pkg::IDX_IMASK, 16'h0001);
    wr(spm_pkg::IDX_ISTAT, 16'h0001);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "cleared");
    rdchk(spm_pkg::IDX_ISTAT, 16'h0002, "frame flag kept");
    $display("done irq");
  endtask : t_irq
  task automatic t_loop();
    int c;
    wr(spm_pkg::IDX_CCR, 16'h0003);
    wr(spm_pkg::IDX_CFG_HI, 16'h0005);
    wr(spm_pkg::IDX_DAT_LO, 16'h5678);
    wr(spm_pkg::IDX_DAT_HI, 16'h1234);
    wr(spm_pkg::IDX_CMD_LO, 16'h0000);
    wr(spm_pkg::IDX_CMD_HI, 16'h007E);
    c = 0;
    while (slave_select_n[2] !== 1'b1 && c < 50) begin
      @(posedge pclk);
      c++;
    end
    chk(slave_select_n, 4'hF, "active high select");
    wait_idle();
    chk(slave_select_n, 4'hB, "select polarity idle");
    chk(serial_clk, 1'b1, "clock idles high");
    rdchk(spm_pkg::IDX_DAT_LO, 16'h5678, "loop low");
    rdchk(spm_pkg::IDX_DAT_HI, 16'h1234, "loop high 32 bit");
    $display("done loop");
  endtask : t_loop
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    #1_000_000;
    n_mismatch++;
    final_report();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    resp = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_mode0();
    t_lead();
    t_irq();
    t_loop();
    final_report();
  end
endmodule : tb_serial_peripheral_master
`default_nettype wire
